//--- dsbl_pkg.sv
package dsbl_pkg;

    //----------------------------------------------------------------
    // Clock and bit timing
    //----------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned OVERSAMPLE  = 16;
    localparam int unsigned BAUD_0      = 2400;
    localparam int unsigned BAUD_1      = 4800;
    localparam int unsigned BAUD_2      = 9600;
    localparam int unsigned BAUD_3      = 19200;
    localparam int unsigned BAUD_4      = 38400;
    localparam int unsigned BAUD_5      = 57600;
    localparam int unsigned BAUD_6      = 76800;
    localparam int unsigned BAUD_7      = 115200;
    localparam logic [3:0]  SUB_LAST    = 4'hf;   // Last oversample tick of a bit
    localparam logic [3:0]  SUB_MID     = 4'h7;   // Oversample tick that samples a bit

    //----------------------------------------------------------------
    // Character framing selections
    //----------------------------------------------------------------
    localparam logic [1:0] FRAME_EVEN_1 = 2'h0;   // Reset default of the configuration
    localparam logic [1:0] FRAME_ODD_1  = 2'h1;
    localparam logic [1:0] FRAME_NONE_2 = 2'h2;
    localparam logic [1:0] FRAME_NONE_1 = 2'h3;
    localparam logic [3:0] FRAME_BITS_11 = 4'hb;
    localparam logic [3:0] FRAME_BITS_10 = 4'ha;

    //----------------------------------------------------------------
    // Telegram constants
    //----------------------------------------------------------------
    localparam logic [7:0] TELEGRAM_START_CHAR = 8'h02;
    localparam logic [7:0] LENGTH_OVERHEAD     = 8'h02;  // Address byte plus check byte
    localparam logic [6:0] ADDR_MAX            = 7'h7e;
    localparam logic [6:0] ADDR_SHORT_MAX      = 7'h1f;
    localparam int unsigned ADDR_FMT_BIT       = 7;
    localparam int unsigned ADDR_BCAST_BIT     = 5;

    //----------------------------------------------------------------
    // Carriers
    //----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] baud_sel;
        logic [1:0] frame_sel;
        logic [6:0] node_addr;
    } dsbl_cfg_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] index;
        logic [7:0] data;
    } dsbl_rx_byte_type;

    //----------------------------------------------------------------
    // Functions
    //----------------------------------------------------------------
    function automatic logic [15:0] baud_div(input logic [2:0] sel);
        int unsigned rate;
        unique case (sel)
            3'h0: rate = BAUD_0;
            3'h1: rate = BAUD_1;
            3'h2: rate = BAUD_2;
            3'h3: rate = BAUD_3;
            3'h4: rate = BAUD_4;
            3'h5: rate = BAUD_5;
            3'h6: rate = BAUD_6;
            3'h7: rate = BAUD_7;
        endcase
        return 16'(CLK_HZ / (rate * OVERSAMPLE) - 1);
    endfunction

    function automatic logic [3:0] frame_bits(input logic [1:0] sel);
        return (sel == FRAME_NONE_1) ? FRAME_BITS_10 : FRAME_BITS_11;
    endfunction

    // Bit 9 carries parity, or a stop bit when parity is off
    function automatic logic parity_slot(input logic [7:0] d, input logic [1:0] sel);
        unique case (sel)
            FRAME_EVEN_1: parity_slot = ^d;
            FRAME_ODD_1:  parity_slot = ~^d;
            FRAME_NONE_2: parity_slot = 1'b1;
            FRAME_NONE_1: parity_slot = 1'b1;
        endcase
    endfunction

endpackage

//--- dsbl_uart.sv
module dsbl_uart (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire dsbl_pkg::dsbl_cfg_type cfg,
    input  wire logic               rxd,
    output logic                    txd,
    output logic                    tx_busy,
    input  wire logic               tx_start,
    input  wire logic [7:0]         tx_byte,
    output logic                    tx_done,
    output logic [7:0]              rx_byte,
    output logic                    rx_valid,
    output logic                    rx_err
);

    typedef struct packed {
        logic [15:0] div;
        logic [3:0]  tsub;
        logic [3:0]  tbit;
        logic        tbusy;
        logic [10:0] tsh;
        logic        tdone;
        logic [3:0]  rsub;
        logic [3:0]  rbit;
        logic        rbusy;
        logic [10:0] rsh;
        logic        rvalid;
        logic        rerr;
    } dsbl_uart_state_type;

    dsbl_uart_state_type s;
    dsbl_uart_state_type next_s;

    //----------------------------------------------------------------
    // Bit engine
    //----------------------------------------------------------------
    // One process for divider, transmitter and receiver
    always_comb begin
        logic       tick;
        logic [3:0] len;
        logic       perr;
        tick   = (s.div == 16'h0000);
        len    = dsbl_pkg::frame_bits(cfg.frame_sel);
        perr   = 1'b0;
        next_s = s;
        next_s.tdone  = 1'b0;
        next_s.rvalid = 1'b0;
        next_s.div    = tick ? dsbl_pkg::baud_div(cfg.baud_sel) : s.div - 16'h0001;
        // Start bit, data LSB first, parity, stop, then idle high
        if (tx_start && !s.tbusy) begin
            next_s.tsh   = {1'b1, dsbl_pkg::parity_slot(tx_byte, cfg.frame_sel),
                            tx_byte, 1'b0};
            next_s.tbusy = 1'b1;
            next_s.tbit  = 4'h0;
            next_s.tsub  = 4'h0;
        end else if (tick && s.tbusy) begin
            next_s.tsub = s.tsub + 4'h1;
            if (s.tsub == dsbl_pkg::SUB_LAST) begin
                next_s.tsh  = {1'b1, s.tsh[10:1]};
                next_s.tbit = s.tbit + 4'h1;
                if (s.tbit == len - 4'h1) begin
                    next_s.tbusy = 1'b0;
                    next_s.tdone = 1'b1;
                end
            end
        end
        // Receiver is deaf while we drive, so our own echo never lands
        if (s.tbusy) begin
            next_s.rbusy = 1'b0;
        end else if (tick && !s.rbusy) begin
            if (!rxd) begin
                next_s.rbusy = 1'b1;
                next_s.rsub  = 4'h1;
                next_s.rbit  = 4'h0;
            end
        end else if (tick) begin
            next_s.rsub = s.rsub + 4'h1;
            if (s.rsub == dsbl_pkg::SUB_MID) begin
                next_s.rsh[s.rbit] = rxd;
                if (s.rbit == 4'h0 && rxd) begin
                    next_s.rbusy = 1'b0; // Start glitch
                end else if (s.rbit == len - 4'h1) begin
                    unique case (cfg.frame_sel)
                        dsbl_pkg::FRAME_EVEN_1: perr = ^s.rsh[9:1];
                        dsbl_pkg::FRAME_ODD_1:  perr = ~^s.rsh[9:1];
                        dsbl_pkg::FRAME_NONE_2: perr = ~s.rsh[9];
                        dsbl_pkg::FRAME_NONE_1: perr = 1'b0;
                    endcase
                    next_s.rbusy  = 1'b0;
                    next_s.rvalid = 1'b1;
                    next_s.rerr   = perr | ~rxd; // Stop bit must be high
                end
            end
            if (s.rsub == dsbl_pkg::SUB_LAST) begin
                next_s.rbit = s.rbit + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s     <= '0;
            s.tsh <= 11'h7ff;
        end else begin
            s <= next_s;
        end
    end

    assign txd      = s.tsh[0];
    assign tx_busy  = s.tbusy;
    assign tx_done  = s.tdone;
    assign rx_byte  = s.rsh[8:1];
    assign rx_valid = s.rvalid;
    assign rx_err   = s.rerr;

endmodule

//--- dsbl_link.sv
module dsbl_link (
    input  wire logic                       CLK,
    input  wire logic                       RST,
    input  wire dsbl_pkg::dsbl_cfg_type     CFG,
    input  wire logic                       RXD,
    output logic                            TXD,
    output logic                            TX_EN,
    output dsbl_pkg::dsbl_rx_byte_type      RX_BYTE,
    output logic                            TEL_OK,
    output logic                            TEL_BCAST,
    output logic                            TEL_ERR,
    output logic                            REPLY_PENDING,
    input  wire logic                       REPLY_GO,
    input  wire logic [7:0]                 REPLY_LEN,
    input  wire logic [7:0]                 REPLY_DATA,
    input  wire logic                       REPLY_VALID,
    output logic                            REPLY_READY,
    output logic                            REPLY_DONE
);

    typedef enum logic [3:0] {
        ST_HUNT    = 4'h0,
        ST_LEN     = 4'h1,
        ST_ADDR    = 4'h2,
        ST_DATA    = 4'h3,
        ST_CHECK   = 4'h4,
        ST_WAIT    = 4'h5,
        ST_TX_STX  = 4'h6,
        ST_TX_LEN  = 4'h7,
        ST_TX_ADDR = 4'h8,
        ST_TX_DATA = 4'h9,
        ST_TX_BCC  = 4'ha
    } dsbl_state_type;

    typedef struct packed {
        dsbl_state_type             st;
        logic [7:0]                 bcc;
        logic [7:0]                 left;
        logic [7:0]                 addr;
        logic                       hit;
        logic                       bcast;
        logic                       sent;
        dsbl_pkg::dsbl_rx_byte_type rxo;
        logic                       ok;
        logic                       bc_out;
        logic                       err;
        logic                       done;
    } dsbl_link_state_type;

    dsbl_link_state_type s;
    dsbl_link_state_type next_s;

    logic       tx_busy;
    logic       tx_start;
    logic [7:0] tx_byte;
    logic       tx_done;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       rx_err;

    //----------------------------------------------------------------
    // Address decode
    //----------------------------------------------------------------
    // Returns {addressed to us or broadcast, broadcast}
    function automatic logic [1:0] addr_match(input logic [7:0] a, input logic [6:0] node);
        logic bc;
        logic me;
        if (a[dsbl_pkg::ADDR_FMT_BIT]) begin
            bc = (a[6:0] == 7'h00);
            me = (a[6:0] == node);
        end else begin
            bc = a[dsbl_pkg::ADDR_BCAST_BIT];
            me = !bc && (node <= dsbl_pkg::ADDR_SHORT_MAX) && (a[4:0] == node[4:0]);
        end
        // A node address outside 1..126 answers nothing
        me = me && (node != 7'h00) && (node <= dsbl_pkg::ADDR_MAX);
        addr_match = {me | bc, bc};
    endfunction

    //----------------------------------------------------------------
    // Character engine
    //----------------------------------------------------------------
    // Bit rate, framing and bit order all live in the engine
    dsbl_uart u_uart (
        .clk      (CLK),
        .rst      (RST),
        .cfg      (CFG),
        .rxd      (RXD),
        .txd      (TXD),
        .tx_busy  (tx_busy),
        .tx_start (tx_start),
        .tx_byte  (tx_byte),
        .tx_done  (tx_done),
        .rx_byte  (rx_byte),
        .rx_valid (rx_valid),
        .rx_err   (rx_err)
    );

    //----------------------------------------------------------------
    // Handshake outputs
    //----------------------------------------------------------------
    // Data is pulled only when the engine can take it at once
    assign REPLY_READY = (s.st == ST_TX_DATA) && !s.sent && !tx_busy;
    assign tx_start    = (s.st == ST_TX_DATA) ? (REPLY_READY && REPLY_VALID)
                       : ((s.st >= ST_TX_STX) && !s.sent && !tx_busy);

    // Outgoing byte for each reply state; check byte covers all earlier bytes
    always_comb begin
        unique case (s.st)
            ST_TX_STX:  tx_byte = dsbl_pkg::TELEGRAM_START_CHAR;
            ST_TX_LEN:  tx_byte = s.left + dsbl_pkg::LENGTH_OVERHEAD;
            ST_TX_ADDR: tx_byte = s.addr; // Echoed unchanged
            ST_TX_DATA: tx_byte = REPLY_DATA;
            ST_TX_BCC:  tx_byte = s.bcc;
            default:    tx_byte = 8'h00;
        endcase
    end

    //----------------------------------------------------------------
    // Telegram sequencer
    //----------------------------------------------------------------
    always_comb begin
        logic [1:0] m;
        m      = addr_match(rx_byte, CFG.node_addr);
        next_s = s;
        next_s.rxo.valid = 1'b0;
        next_s.ok        = 1'b0;
        next_s.bc_out    = 1'b0;
        next_s.err       = 1'b0;
        next_s.done      = 1'b0;
        if (tx_start) begin
            next_s.sent = 1'b1;
            next_s.bcc  = s.bcc ^ tx_byte;
        end
        unique case (s.st)
            ST_HUNT: begin
                // Resync on the start char; checksum seeded from it
                if (rx_valid && !rx_err && rx_byte == dsbl_pkg::TELEGRAM_START_CHAR) begin
                    next_s.st  = ST_LEN;
                    next_s.bcc = rx_byte;
                end
            end
            ST_LEN, ST_ADDR, ST_DATA, ST_CHECK: begin
                if (rx_valid && rx_err) begin
                    next_s.st  = ST_HUNT; // Corrupt character kills the telegram
                    next_s.err = 1'b1;
                end else if (rx_valid) begin
                    next_s.bcc = s.bcc ^ rx_byte;
                    unique case (s.st)
                        ST_LEN: begin
                            // Length of any format, text ones included
                            next_s.left = rx_byte - dsbl_pkg::LENGTH_OVERHEAD;
                            next_s.st   = (rx_byte < dsbl_pkg::LENGTH_OVERHEAD) ? ST_HUNT
                                                                                : ST_ADDR;
                        end
                        ST_ADDR: begin
                            next_s.addr  = rx_byte;
                            next_s.hit   = m[1];
                            next_s.bcast = m[0];
                            next_s.rxo.index = 8'hff; // First data byte wraps to index 0
                            next_s.st    = (s.left == 8'h00) ? ST_CHECK : ST_DATA;
                        end
                        ST_DATA: begin
                            // Foreign telegrams are tracked but not passed on
                            next_s.rxo.valid = s.hit;
                            next_s.rxo.data  = rx_byte;
                            next_s.rxo.index = s.rxo.index + 8'h01;
                            next_s.left = s.left - 8'h01;
                            if (s.left == 8'h01) begin
                                next_s.st = ST_CHECK;
                            end
                        end
                        default: begin
                            // Check byte: XOR of all earlier bytes must equal it
                            next_s.st = ST_HUNT;
                            if (s.bcc != rx_byte) begin
                                next_s.err = 1'b1;
                            end else if (s.hit) begin
                                next_s.ok     = 1'b1;
                                next_s.bc_out = s.bcast;
                                // Broadcasts get no answer
                                if (!s.bcast) begin
                                    next_s.st = ST_WAIT;
                                end
                            end
                        end
                    endcase
                end
            end
            ST_WAIT: begin
                // Master gave up and talks again: abandon the reply
                if (rx_valid) begin
                    next_s.st = ST_HUNT;
                end else if (REPLY_GO) begin
                    next_s.st   = ST_TX_STX; // Answer only the request just taken
                    next_s.left = REPLY_LEN;
                    next_s.bcc  = 8'h00;
                    next_s.sent = 1'b0;
                end
            end
            default: begin
                if (tx_done) begin
                    next_s.sent = 1'b0;
                    unique case (s.st)
                        ST_TX_STX:  next_s.st = ST_TX_LEN;
                        ST_TX_LEN:  next_s.st = ST_TX_ADDR;
                        ST_TX_ADDR: next_s.st = (s.left == 8'h00) ? ST_TX_BCC : ST_TX_DATA;
                        ST_TX_DATA: begin
                            next_s.left = s.left - 8'h01;
                            if (s.left == 8'h01) begin
                                next_s.st = ST_TX_BCC;
                            end
                        end
                        default: begin
                            next_s.st   = ST_HUNT;
                            next_s.done = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s    <= '0;
            s.st <= ST_HUNT;
        end else begin
            s <= next_s;
        end
    end

    //----------------------------------------------------------------
    // Outputs
    //----------------------------------------------------------------
    // Driver enable follows the engine, released after the stop bit
    assign TX_EN         = tx_busy;
    assign RX_BYTE       = s.rxo;
    assign TEL_OK        = s.ok;
    assign TEL_BCAST     = s.bc_out;
    assign TEL_ERR       = s.err;
    assign REPLY_PENDING = (s.st == ST_WAIT);
    assign REPLY_DONE    = s.done;

endmodule

//--- dsbl_link_properties.sv
module dsbl_link_chk (
    input wire logic CLK,
    input wire logic RST,
    input wire logic TXD,
    input wire logic TX_EN,
    input wire logic TEL_OK,
    input wire logic TEL_BCAST,
    input wire logic TEL_ERR,
    input wire logic REPLY_PENDING,
    input wire logic REPLY_GO,
    input wire logic REPLY_DONE
);
    timeunit 1ns;
    timeprecision 1ns;
    //------------------------------------------------------------
    // Reply gating and transmit framing
    //------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    // A reply may only be armed by a good telegram sent to us alone
    chk_pend_needs_ok: assert property ($rose(REPLY_PENDING) |-> TEL_OK && !TEL_BCAST)
        else $error("reply armed without a good private telegram");
    chk_idle_high: assert property (!TX_EN |-> TXD)
        else $error("line not idle high while driver is off");
    // The sequencer steps first, the engine loads one edge later
    chk_go_start: assert property (REPLY_PENDING && REPLY_GO |-> ##2 TX_EN && !TXD)
        else $error("reply start did not open a start bit");
    chk_start_width: assert property ($rose(TX_EN) |-> !TXD [*8])
        else $error("start bit cut short");
    chk_bcast_ok: assert property (TEL_BCAST |-> TEL_OK)
        else $error("broadcast flag without good telegram");
    chk_ok_xor_err: assert property (!(TEL_OK && TEL_ERR))
        else $error("telegram both good and bad");
    chk_quiet_pending: assert property (REPLY_PENDING |-> !TX_EN)
        else $error("driver on while waiting to reply");
    // Done comes one cycle after the driver lets go at the end of a stop bit
    chk_done_stop: assert property (
        REPLY_DONE |-> !TX_EN && !$past(TX_EN) && $past(TX_EN, 2) && $past(TXD, 2))
        else $error("reply end without stop bit or release");
endmodule

bind dsbl_link dsbl_link_chk dsbl_link_chk_i (.CLK, .RST, .TXD, .TX_EN, .TEL_OK, .TEL_BCAST,
    .TEL_ERR, .REPLY_PENDING, .REPLY_GO, .REPLY_DONE);

//--- dsbl_master_model.sv
module dsbl_master_model #(
    parameter int BIT = 432
) (
    input  wire logic clk,
    input  wire logic line,
    output logic      drv
);
    timeunit 1ns;
    timeprecision 1ns;
    //------------------------------------------------------------
    // Single bus master, speaks only while the slave is silent
    //------------------------------------------------------------
    // Released line reads high through the biased termination
    initial drv = 1'b1;

    // Start, data LSB first, even parity, one stop
    task automatic send_byte(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ^b, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(negedge clk) drv = f[i];
            repeat (BIT - 1) @(negedge clk);
        end
    endtask

    // Samples mid bit; returns at mid stop so the next start is not missed
    task automatic get_byte(output logic [7:0] b, output logic bad);
        logic [10:0] f;
        @(negedge line);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            f[i] = line;
            if (i < 10) repeat (BIT) @(posedge clk);
        end
        b = f[8:1];
        bad = f[0] | ~f[10] | (^f[9:1]);
    endtask
endmodule

//--- dsbl_tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OS = dsbl_pkg::OVERSAMPLE;
    localparam int BIT = (dsbl_pkg::CLK_HZ / (dsbl_pkg::BAUD_7 * OS)) * OS;
    logic                       clk, rst, m_drv, bus, reply_go, reply_valid;
    logic                       txd, tx_en, tel_ok, tel_bcast, tel_err, pend, ready, done;
    logic [7:0]                 reply_len, reply_data, rx_d, rx_i, rx_n, ok_n, bc_n, er_n, dn_n;
    dsbl_pkg::dsbl_cfg_type     cfg;
    dsbl_pkg::dsbl_rx_byte_type rx_byte;
    int                         bad_count, n_checks, cyc;

    // Half-duplex wire: the slave owns it only while its driver is on
    assign bus = tx_en ? txd : m_drv;

    dsbl_link dsbl_link_i (.CLK(clk), .RST(rst), .CFG(cfg), .RXD(bus), .TXD(txd),
        .TX_EN(tx_en), .RX_BYTE(rx_byte), .TEL_OK(tel_ok), .TEL_BCAST(tel_bcast),
        .TEL_ERR(tel_err), .REPLY_PENDING(pend), .REPLY_GO(reply_go), .REPLY_LEN(reply_len),
        .REPLY_DATA(reply_data), .REPLY_VALID(reply_valid), .REPLY_READY(ready),
        .REPLY_DONE(done));
    dsbl_master_model #(.BIT(BIT)) dsbl_master_model_i (.clk(clk), .line(bus), .drv(m_drv));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Pulse counters and hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            bad_count++;
            tally_and_finish();
        end
        if (rx_byte.valid === 1'b1) begin
            rx_n++;
            rx_d = rx_byte.data;
            rx_i = rx_byte.index;
        end
        if (tel_ok === 1'b1) ok_n++;
        if (tel_bcast === 1'b1) bc_n++;
        if (tel_err === 1'b1) er_n++;
        if (done === 1'b1) dn_n++;
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Master telegram: start char, length, address, len-2 data bytes from d up, check byte
    task automatic send_tel(input logic [7:0] len, adr, d, flip);
        logic [7:0] x;
        x = 8'h02 ^ len ^ adr;
        dsbl_master_model_i.send_byte(8'h02);
        dsbl_master_model_i.send_byte(len);
        dsbl_master_model_i.send_byte(adr);
        for (int k = 2; k < len; k++) begin
            dsbl_master_model_i.send_byte(d + 8'(k - 2));
            x ^= d + 8'(k - 2);
        end
        dsbl_master_model_i.send_byte(x ^ flip);
    endtask

    task automatic s_private_reply;
        logic [7:0] got [5];
        logic       pe [5];
        logic [7:0] exp [5];
        exp = '{8'h02, 8'h03, 8'h85, 8'h3c, 8'h02 ^ 8'h03 ^ 8'h85 ^ 8'h3c};
        send_tel(8'h04, 8'h85, 8'ha5, 8'h00);
        chk("rx count", rx_n, 8'h02);
        chk("rx data", rx_d, 8'ha6);
        chk("rx index", rx_i, 8'h01);
        chk("tel ok", ok_n, 8'h01);
        chk("pending", {7'h0, pend}, 8'h01);
        fork
            for (int i = 0; i < 5; i++) dsbl_master_model_i.get_byte(got[i], pe[i]);
            begin
                @(negedge clk) begin
                    reply_go = 1'b1;
                    reply_len = 8'h01;
                    reply_valid = 1'b1;
                    reply_data = 8'h3c;
                end
                @(negedge clk) reply_go = 1'b0;
                for (int k = 0; k < 30000 && ready !== 1'b1; k++) @(negedge clk);
                @(negedge clk) reply_valid = 1'b0;
            end
        join
        for (int k = 0; k < 2000 && dn_n == 8'h00; k++) @(negedge clk);
        for (int i = 0; i < 5; i++) begin
            chk("reply byte", got[i], exp[i]);
            chk("reply framing", {7'h0, pe[i]}, 8'h00);
        end
        chk("reply done", dn_n, 8'h01);
        chk("line idle", {7'h0, bus}, 8'h01);
    endtask

    // Broadcast in the short format: accepted but never answered
    task automatic s_broadcast;
        send_tel(8'h02, 8'h20, 8'h00, 8'h00);
        chk("bcast ok", ok_n, 8'h02);
        chk("bcast flag", bc_n, 8'h01);
        chk("bcast pending", {7'h0, pend}, 8'h00);
    endtask

    // Foreign long-format address with a corrupt check byte
    task automatic s_foreign_bad;
        send_tel(8'h02, 8'h86, 8'h00, 8'h01);
        chk("bad check err", er_n, 8'h01);
        chk("foreign ok", ok_n, 8'h02);
        chk("foreign rx", rx_n, 8'h02);
        chk("foreign pending", {7'h0, pend}, 8'h00);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        {rx_n, ok_n, bc_n, er_n, dn_n, rx_d, rx_i} = '0;
        {rst, reply_go, reply_valid, reply_len, reply_data} = {1'b1, 18'h0};
        cfg = '{baud_sel: 3'h7, frame_sel: dsbl_pkg::FRAME_EVEN_1, node_addr: 7'h05};
        repeat (16) @(negedge clk);
        rst = 1'b0;
        s_private_reply();
        s_broadcast();
        s_foreign_bad();
        tally_and_finish();
    end
endmodule
